// file: verilog/bus_cycle_unit.sv
// bus cycle definition, bus lock and pseudo lock outputs of the external bus unit
`timescale 1ns/1ns
`default_nettype none
`include "bus_cycle_defs.svh"
// -----------------------------------------------------------------------------
// Overview of operation
// [R1] three outputs encode each cycle type
// [R2] cycle code valid with address strobe
// [R3] cycle code floats during bus hold
// [R4] no bus hold while locked; address hold allowed
// [R5] lock from first locked clock until ready
// [R6] locked reads never become line fills
// [R7] pseudo lock for multi-cycle transactions
// [R8] pseudo lock until final addresses driven
// [R9] pseudo lock inverse of last burst, except
// [R10] pseudo lock follows size and cache pins
// [R11] partner samples pseudo lock only at ready
// [R12] pseudo lock active low, floats in hold
// [R13] strobe with address; floats in hold
// [R14] ready ignored when idle, first clock
// [R15] cycle code stable until ready
// -----------------------------------------------------------------------------

module bus_cycle_unit (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   req_valid_i,
  input  wire bus_cycle_pkg::bus_req_t req_i,
  input  wire logic                   ready_n_i,
  input  wire logic                   burst_ready_n_i,
  input  wire logic                   size8_request_n_i,
  input  wire logic                   size16_request_n_i,
  input  wire logic                   cache_enable_in_n_i,
  input  wire logic                   bus_hold_req_i,
  input  wire logic                   addr_hold_req_i,
  output logic                        req_taken_o,
  output logic                        cycle_done_o,
  output logic                        address_strobe_n_o,
  output logic                        address_strobe_oe_o,
  output logic                        memory_or_io_o,
  output logic                        data_or_control_o,
  output logic                        write_or_read_o,
  output logic                        cycle_def_oe_o,
  output logic                        bus_lock_n_o,
  output logic                        bus_lock_oe_o,
  output logic                        pseudo_lock_n_o,
  output logic                        pseudo_lock_oe_o,
  output logic                        last_burst_n_o,
  output logic                        hold_ack_o
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  bus_cycle_pkg::bus_state_t  st;
  bus_cycle_pkg::bus_state_t  next_st;
  bus_cycle_pkg::cycle_code_t req_code;
  logic [4:0]                 left_after;
  logic [4:0]                 req_total;
  logic                       req_fill_ok;
  logic                       req_fp_write;
  logic                       ready;

  cycle_code_enc u_enc (
    .kind_i (req_i.kind),
    .code_o (req_code)
  );

  transfer_count u_count (
    .first_i             (st.first),
    .fill_ok_i           (st.fill_ok),
    .left_i              (st.left),
    .size8_request_n_i   (size8_request_n_i),
    .size16_request_n_i  (size16_request_n_i),
    .cache_enable_in_n_i (cache_enable_in_n_i),
    .left_after_o        (left_after)
  );

  always_comb begin
    ready        = !ready_n_i || !burst_ready_n_i;
    req_total    = (req_i.xact == bus_cycle_pkg::XACT_SINGLE) ? `BYTES_WORD : `BYTES_DOUBLE; // [R7]
    // a locked read is never widened into a line fill
    req_fill_ok  = (req_i.xact == bus_cycle_pkg::XACT_SINGLE) && !req_i.lock && !st.locked && // [R6]
                   (req_i.kind == bus_cycle_pkg::KIND_CODE_READ ||
                    req_i.kind == bus_cycle_pkg::KIND_MEM_READ);
    req_fp_write = (req_i.xact == bus_cycle_pkg::XACT_FP_DOUBLE) &&
                   (req_i.kind == bus_cycle_pkg::KIND_MEM_WRITE);
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.req_taken  = 1'b0;
    next_st.cycle_done = 1'b0;
    unique case (st.phase)
      bus_cycle_pkg::PH_IDLE: begin
        if (bus_hold_req_i && !st.locked) begin                          // [R4]
          next_st.phase    = bus_cycle_pkg::PH_HOLD;
          next_st.bus_oe   = 1'b0;                                       // [R3] [R12] [R13]
          next_st.hold_ack = 1'b1;
        end else if (req_valid_i && !addr_hold_req_i) begin              // [R4]
          next_st.phase     = bus_cycle_pkg::PH_STROBE;
          next_st.strobe_n  = 1'b0;                                      // [R13]
          next_st.code      = req_code;                                  // [R1] [R2]
          next_st.req_taken = 1'b1;
          next_st.fill_ok   = req_fill_ok;
          next_st.fp_write  = req_fp_write;
          next_st.first     = 1'b1;
          next_st.left      = req_total;
          next_st.lock_end  = req_i.lock_end;
          next_st.pseudo_lock_n   = (req_total <= `BYTES_WORD);               // [R7]
          next_st.last_burst_n   = req_fp_write ? 1'b0 : (req_total > `BYTES_WORD); // [R9]
          if (req_i.lock) begin
            next_st.locked = 1'b1;
            next_st.lock_n = 1'b0;                                       // [R5]
          end
        end
      end
      bus_cycle_pkg::PH_STROBE: begin
        // ready at the end of the strobe clock is ignored
        next_st.phase    = bus_cycle_pkg::PH_WAIT;                       // [R14]
        next_st.strobe_n = 1'b1;
        next_st.pseudo_lock_n  = (left_after == `BYTES_NONE);                  // [R10]
        next_st.last_burst_n  = st.fp_write ? 1'b0 : (left_after != `BYTES_NONE); // [R9]
      end
      bus_cycle_pkg::PH_WAIT: begin
        next_st.pseudo_lock_n = (left_after == `BYTES_NONE);                   // [R8] [R10]
        next_st.last_burst_n = st.fp_write ? 1'b0 : (left_after != `BYTES_NONE);
        if (ready) begin                                                 // [R15]
          next_st.cycle_done = 1'b1;
          next_st.first      = 1'b0;
          next_st.left       = left_after;
          if (left_after != `BYTES_NONE) begin
            if (addr_hold_req_i) begin
              next_st.phase = bus_cycle_pkg::PH_BETWEEN;
            end else begin
              next_st.phase    = bus_cycle_pkg::PH_STROBE;
              next_st.strobe_n = 1'b0;
            end
          end else begin
            next_st.phase   = bus_cycle_pkg::PH_IDLE;
            next_st.pseudo_lock_n = 1'b1;
            next_st.last_burst_n = 1'b1;
            if (st.lock_end) begin
              next_st.locked = 1'b0;
              next_st.lock_n = 1'b1;                                     // [R5]
            end
          end
        end
      end
      bus_cycle_pkg::PH_BETWEEN: begin
        if (!addr_hold_req_i) begin
          next_st.phase    = bus_cycle_pkg::PH_STROBE;
          next_st.strobe_n = 1'b0;
        end
      end
      bus_cycle_pkg::PH_HOLD: begin
        if (!bus_hold_req_i) begin
          next_st.phase    = bus_cycle_pkg::PH_IDLE;
          next_st.bus_oe   = 1'b1;
          next_st.hold_ack = 1'b0;
        end
      end
      default: begin
        next_st.phase = bus_cycle_pkg::PH_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '{phase: bus_cycle_pkg::PH_IDLE, code: `CYC_MEM_READ, strobe_n: 1'b1, bus_oe: 1'b1,
             lock_n: 1'b1, pseudo_lock_n: 1'b1, last_burst_n: 1'b1, locked: 1'b0, lock_end: 1'b0,
             fill_ok: 1'b0, fp_write: 1'b0, first: 1'b0, left: `BYTES_NONE, hold_ack: 1'b0,
             req_taken: 1'b0, cycle_done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------------------
  assign req_taken_o         = st.req_taken;
  assign cycle_done_o        = st.cycle_done;
  assign address_strobe_n_o  = st.strobe_n;
  assign address_strobe_oe_o = st.bus_oe;
  assign memory_or_io_o      = st.code.memory_or_io;
  assign data_or_control_o   = st.code.data_or_control;
  assign write_or_read_o     = st.code.write_or_read;
  assign cycle_def_oe_o      = st.bus_oe;
  assign bus_lock_n_o        = st.lock_n;
  assign bus_lock_oe_o       = st.bus_oe;
  assign pseudo_lock_n_o     = st.pseudo_lock_n;
  assign pseudo_lock_oe_o    = st.bus_oe;
  assign last_burst_n_o      = st.last_burst_n;
  assign hold_ack_o          = st.hold_ack;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_strobe;
    !st.strobe_n && st.phase == bus_cycle_pkg::PH_STROBE;
  endsequence

  sequence s_open;
    st.phase == bus_cycle_pkg::PH_WAIT && !ready;
  endsequence

  property p_code_map;
    next_st.req_taken |=> st.code == $past(req_code) && st.code != `CYC_RESERVED;
  endproperty
  a_code_map: assert property (p_code_map) else $error("cycle code does not match request"); // [R1]

  property p_code_with_strobe;
    s_strobe |-> st.bus_oe && st.code != `CYC_RESERVED;
  endproperty
  a_code_with_strobe: assert property (p_code_with_strobe) else $error("strobe without driven code"); // [R2]

  property p_float_in_hold;
    st.hold_ack |-> !cycle_def_oe_o && !bus_lock_oe_o && !pseudo_lock_oe_o && !address_strobe_oe_o;
  endproperty
  a_float_in_hold: assert property (p_float_in_hold) else $error("pins driven during bus hold"); // [R3]

  property p_no_hold_locked;
    $rose(st.hold_ack) |-> !$past(st.locked);
  endproperty
  a_no_hold_locked: assert property (p_no_hold_locked) else $error("bus hold granted while locked"); // [R4]

  property p_lock_first_clock;
    $fell(st.lock_n) |-> s_strobe;
  endproperty
  a_lock_first_clock: assert property (p_lock_first_clock) else $error("lock not raised with strobe"); // [R5]

  property p_lock_release;
    $rose(st.lock_n) |-> $past(st.phase == bus_cycle_pkg::PH_WAIT && ready && st.lock_end);
  endproperty
  a_lock_release: assert property (p_lock_release) else $error("lock dropped before ready"); // [R5]

  property p_no_locked_fill;
    st.locked && st.phase != bus_cycle_pkg::PH_IDLE |-> !st.fill_ok && st.left <= `BYTES_DOUBLE;
  endproperty
  a_no_locked_fill: assert property (p_no_locked_fill) else $error("locked read widened to fill"); // [R6]

  property p_pseudo_lock_inverse;
    st.phase == bus_cycle_pkg::PH_WAIT && !st.fp_write |-> st.last_burst_n == !st.pseudo_lock_n;
  endproperty
  a_pseudo_lock_inverse: assert property (p_pseudo_lock_inverse) else $error("pseudo lock not inverse of last"); // [R9]

  property p_fp_write_both;
    st.phase == bus_cycle_pkg::PH_WAIT && st.fp_write && !st.pseudo_lock_n |-> !st.last_burst_n;
  endproperty
  a_fp_write_both: assert property (p_fp_write_both) else $error("fp write first cycle not both"); // [R9]

  property p_pseudo_lock_final;
    st.phase == bus_cycle_pkg::PH_WAIT && ready && !st.pseudo_lock_n && left_after != `BYTES_NONE
      |=> ##[0:1] (!st.strobe_n || st.phase == bus_cycle_pkg::PH_BETWEEN);
  endproperty
  a_pseudo_lock_final: assert property (p_pseudo_lock_final) else $error("pseudo lock without follow cycle"); // [R8]

  property p_ready_ignored_first;
    s_strobe |=> !st.cycle_done ##1 st.phase != bus_cycle_pkg::PH_STROBE || st.cycle_done;
  endproperty
  a_ready_ignored_first: assert property (p_ready_ignored_first) else $error("ready taken in strobe clock"); // [R14]

  property p_code_stable;
    s_open |=> $stable(st.code) && st.strobe_n;
  endproperty
  a_code_stable: assert property (p_code_stable) else $error("cycle code changed before ready"); // [R15]

  property p_taken_with_strobe;
    st.req_taken |-> s_strobe;
  endproperty
  a_taken_with_strobe: assert property (p_taken_with_strobe) else $error("request taken without strobe"); // [R2]

  property p_strobe_one_clock;
    s_strobe |=> st.strobe_n;
  endproperty
  a_strobe_one_clock: assert property (p_strobe_one_clock) else $error("strobe longer than one clock"); // [R13]

  property p_pseudo_lock_multi;
    next_st.req_taken && req_i.xact != bus_cycle_pkg::XACT_SINGLE |=> !st.pseudo_lock_n;
  endproperty
  a_pseudo_lock_multi: assert property (p_pseudo_lock_multi) else $error("pseudo lock missing on multi-cycle request"); // [R7]

  property p_lock_held;
    st.locked |-> !st.lock_n && st.bus_oe;
  endproperty
  a_lock_held: assert property (p_lock_held) else $error("lock not driven while locked"); // [R5]

  property p_hold_refused;
    bus_hold_req_i && st.locked |=> !st.hold_ack;
  endproperty
  a_hold_refused: assert property (p_hold_refused) else $error("bus hold granted during lock"); // [R4]

endmodule : bus_cycle_unit
`default_nettype wire

// file: common/bus_cycle_defs.svh
// constants of the bus cycle definition unit
`ifndef BUS_CYCLE_DEFS_SVH
`define BUS_CYCLE_DEFS_SVH

// -----------------------------------------------------------------------------
// cycle definition codes, bit order memory_or_io, data_or_control, write_or_read
// -----------------------------------------------------------------------------
`define CYC_INT_ACK   3'h0
`define CYC_SPECIAL   3'h1
`define CYC_IO_READ   3'h2
`define CYC_IO_WRITE  3'h3
`define CYC_CODE_READ 3'h4
`define CYC_RESERVED  3'h5
`define CYC_MEM_READ  3'h6
`define CYC_MEM_WRITE 3'h7

// -----------------------------------------------------------------------------
// transaction sizes and transfer widths in bytes
// -----------------------------------------------------------------------------
`define BYTES_WORD    5'h04
`define BYTES_DOUBLE  5'h08
`define BYTES_LINE    5'h10
`define STEP_SIZE8    5'h01
`define STEP_SIZE16   5'h02
`define STEP_SIZE32   5'h04
`define BYTES_NONE    5'h00

`endif

// file: common/bus_cycle_pkg.sv
// types of the bus cycle definition unit
package bus_cycle_pkg;

  // ---------------------------------------------------------------------------
  // request from the core side
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_INT_ACK,
    KIND_SPECIAL,
    KIND_IO_READ,
    KIND_IO_WRITE,
    KIND_CODE_READ,
    KIND_MEM_READ,
    KIND_MEM_WRITE
  } cycle_kind_t;

  typedef enum logic [1:0] {
    XACT_SINGLE,
    XACT_FP_DOUBLE,
    XACT_DESCRIPTOR
  } xact_t;

  typedef struct packed {
    cycle_kind_t kind;
    xact_t       xact;
    logic        lock;
    logic        lock_end;
  } bus_req_t;

  // ---------------------------------------------------------------------------
  // cycle definition pins and unit state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic memory_or_io;
    logic data_or_control;
    logic write_or_read;
  } cycle_code_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_STROBE,
    PH_WAIT,
    PH_BETWEEN,
    PH_HOLD
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    cycle_code_t code;
    logic        strobe_n;
    logic        bus_oe;
    logic        lock_n;
    logic        pseudo_lock_n;
    logic        last_burst_n;
    logic        locked;
    logic        lock_end;
    logic        fill_ok;
    logic        fp_write;
    logic        first;
    logic [4:0]  left;
    logic        hold_ack;
    logic        req_taken;
    logic        cycle_done;
  } bus_state_t;

endpackage : bus_cycle_pkg

// file: verilog/cycle_code_enc.sv
// maps a request kind onto the three cycle definition bits
`timescale 1ns/1ns
`default_nettype none
`include "bus_cycle_defs.svh"

module cycle_code_enc (
  input  wire bus_cycle_pkg::cycle_kind_t kind_i,
  output var  bus_cycle_pkg::cycle_code_t code_o
);

  always_comb begin
    unique case (kind_i)
      bus_cycle_pkg::KIND_INT_ACK:   code_o = `CYC_INT_ACK;
      bus_cycle_pkg::KIND_SPECIAL:   code_o = `CYC_SPECIAL;
      bus_cycle_pkg::KIND_IO_READ:   code_o = `CYC_IO_READ;
      bus_cycle_pkg::KIND_IO_WRITE:  code_o = `CYC_IO_WRITE;
      bus_cycle_pkg::KIND_CODE_READ: code_o = `CYC_CODE_READ;
      bus_cycle_pkg::KIND_MEM_READ:  code_o = `CYC_MEM_READ;
      bus_cycle_pkg::KIND_MEM_WRITE: code_o = `CYC_MEM_WRITE;
      // unused enum code: fall back to a plain memory read, never the reserved code
      default:                       code_o = `CYC_MEM_READ;
    endcase
  end

endmodule : cycle_code_enc
`default_nettype wire

// file: verilog/transfer_count.sv
// bytes left after the current transfer, from sampled size and cache pins
`timescale 1ns/1ns
`default_nettype none
`include "bus_cycle_defs.svh"

module transfer_count (
  input  wire logic       first_i,
  input  wire logic       fill_ok_i,
  input  wire logic [4:0] left_i,
  input  wire logic       size8_request_n_i,
  input  wire logic       size16_request_n_i,
  input  wire logic       cache_enable_in_n_i,
  output var  logic [4:0] left_after_o
);

  logic [4:0] base;
  logic [4:0] step;

  always_comb begin
    // a cacheable first read grows into a whole line
    base = (first_i && fill_ok_i && !cache_enable_in_n_i) ? `BYTES_LINE : left_i;
    if (!size8_request_n_i) begin
      step = `STEP_SIZE8;
    end else if (!size16_request_n_i) begin
      step = `STEP_SIZE16;
    end else begin
      step = `STEP_SIZE32;
    end
    left_after_o = (base > step) ? 5'(base - step) : `BYTES_NONE;
  end

endmodule : transfer_count
`default_nettype wire

// file: sim/bus_sys_model.sv
// ready generator standing in for the system bus logic
`timescale 1ns/1ns
`default_nettype none

module bus_sys_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       address_strobe_n_i,
  input  wire logic       address_strobe_oe_i,
  input  wire logic [2:0] rnd_i,
  output logic            ready_n_o,
  output logic            burst_ready_n_o
);
  logic       busy;
  logic [1:0] wait_cnt;

  // ---------------------------------------------------------------------------
  // one ready per strobe, after 1 to 4 wait clocks
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy            <= 1'h0;
      wait_cnt        <= 2'h0;
      ready_n_o       <= 1'h1;
      burst_ready_n_o <= 1'h1;
    end else begin
      ready_n_o       <= 1'h1;
      burst_ready_n_o <= 1'h1;
      if (!address_strobe_n_i && address_strobe_oe_i) begin
        busy     <= 1'h1;
        wait_cnt <= rnd_i[1:0];
      end else if (busy && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (busy) begin
        busy <= 1'h0;
        if (rnd_i[2]) burst_ready_n_o <= 1'h0;
        else ready_n_o <= 1'h0;
      end
    end
  end
endmodule : bus_sys_model
`default_nettype wire

// file: sim/tb_cpu_bus_cycle_definition.sv
// self-checking bench of the bus cycle definition unit
`timescale 1ns/1ns
`default_nettype none

module tb_cpu_bus_cycle_definition;
  // ---------------------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------------------
  logic                    clk_i     = 1'h0;
  logic                    nrst_i    = 1'h0;
  logic                    req_valid = 1'h0;
  bus_cycle_pkg::bus_req_t req       = '0;
  logic                    size8_n   = 1'h1;
  logic                    size16_n  = 1'h1;
  logic                    ken_n     = 1'h1;
  logic                    bus_hold  = 1'h0;
  logic                    addr_hold = 1'h0;
  logic [31:0]             lfsr      = 32'h27f10e04;
  logic                    locked    = 1'h0;
  logic                    ready_n, burst_ready_n, req_taken_o, cycle_done, strobe_n, strobe_oe, def_oe;
  logic                    mem_io, dat_ctl, wr_rd, lock_n, lock_oe, pseudo_lock_n, pseudo_lock_oe, last_burst_n, hold_ack;
  logic [2:0]              exp_code;
  logic                    cur_lock, fp_write;
  int                      err_total  = 0;
  int                      n_compared = 0;
  int                      n_strobe, n_rdy, n_done, exp_n;

  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  always @(posedge clk_i) lfsr <= lfsr_next(lfsr);

  bus_cycle_unit bus_cycle_unit_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid), .req_i(req), .ready_n_i(ready_n),
    .burst_ready_n_i(burst_ready_n), .size8_request_n_i(size8_n), .size16_request_n_i(size16_n),
    .cache_enable_in_n_i(ken_n), .bus_hold_req_i(bus_hold), .addr_hold_req_i(addr_hold),
    .req_taken_o(req_taken_o), .cycle_done_o(cycle_done), .address_strobe_n_o(strobe_n),
    .address_strobe_oe_o(strobe_oe), .memory_or_io_o(mem_io), .data_or_control_o(dat_ctl),
    .write_or_read_o(wr_rd), .cycle_def_oe_o(def_oe), .bus_lock_n_o(lock_n), .bus_lock_oe_o(lock_oe),
    .pseudo_lock_n_o(pseudo_lock_n), .pseudo_lock_oe_o(pseudo_lock_oe), .last_burst_n_o(last_burst_n),
    .hold_ack_o(hold_ack)
  );

  bus_sys_model bus_sys_model_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .address_strobe_n_i(strobe_n), .address_strobe_oe_i(strobe_oe),
    .rnd_i(lfsr[2:0]), .ready_n_o(ready_n), .burst_ready_n_o(burst_ready_n)
  );

  // ---------------------------------------------------------------------------
  // expectations and comparison
  // ---------------------------------------------------------------------------
  function automatic logic [2:0] code_of(input bus_cycle_pkg::cycle_kind_t k);
    case (k)
      bus_cycle_pkg::KIND_INT_ACK:   return 3'h0;
      bus_cycle_pkg::KIND_SPECIAL:   return 3'h1;
      bus_cycle_pkg::KIND_IO_READ:   return 3'h2;
      bus_cycle_pkg::KIND_IO_WRITE:  return 3'h3;
      bus_cycle_pkg::KIND_CODE_READ: return 3'h4;
      bus_cycle_pkg::KIND_MEM_READ:  return 3'h6;
      default:                       return 3'h7;
    endcase
  endfunction : code_of

  function automatic int cycles_of(input logic [2:0] k, input logic [1:0] x, input logic lk, s8, s16, kn);
    int bytes;
    bytes = (x == 2'h0) ? 4 : 8;
    if (x == 2'h0 && !lk && !kn && (k == 3'h4 || k == 3'h5)) bytes = 16;
    return bytes / (!s8 ? 1 : (!s16 ? 2 : 4));
  endfunction : cycles_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask : check

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------------------
  // monitor at strobe and ready clocks
  // ---------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (nrst_i && cycle_done) n_done++;
    if (nrst_i && !strobe_n) begin
      n_strobe++;
      check({mem_io, dat_ctl, wr_rd}, exp_code);
      check(lock_n, !cur_lock);
    end
    if (nrst_i && (!ready_n || !burst_ready_n)) begin
      n_rdy++;
      check({mem_io, dat_ctl, wr_rd}, exp_code);
      check(pseudo_lock_n, n_rdy >= exp_n);
      check(last_burst_n, !fp_write && n_rdy < exp_n);
    end
  end

  // ---------------------------------------------------------------------------
  // one transaction; kinds 0..6 int ack to mem write, xact 0 single 1 fp 2 descriptor
  // ---------------------------------------------------------------------------
  task automatic run_xact(input logic [2:0] kv, input logic [1:0] xv, input logic lk, le, s8, s16, kn, ah);
    int n;
    @(posedge clk_i);
    n_strobe = 0;
    n_rdy    = 0;
    n_done   = 0;
    exp_code = code_of(bus_cycle_pkg::cycle_kind_t'(kv));
    cur_lock = lk | locked;
    fp_write = (kv == 3'h6) && (xv == 2'h1);
    exp_n    = cycles_of(kv, xv, cur_lock, s8, s16, kn);
    size8_n   <= s8;
    size16_n  <= s16;
    ken_n     <= kn;
    addr_hold <= ah;
    req       <= {kv, xv, lk, le};
    req_valid <= 1'h1;
    if (ah) begin
      repeat (4) @(posedge clk_i);
      check(n_strobe, 0);
      addr_hold <= 1'h0;
    end
    n = 0;
    while (req_taken_o !== 1'h1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (req_taken_o !== 1'h1) err_total++;
    req_valid <= 1'h0;
    n = 0;
    while (n_rdy < exp_n && n < 400) begin
      addr_hold <= ah & lfsr[3];
      @(posedge clk_i);
      n++;
    end
    addr_hold <= 1'h0;
    if (n_rdy < exp_n) err_total++;
    repeat (2) @(posedge clk_i);
    check(n_strobe, exp_n);
    check(n_done, exp_n);
    if (le) locked = 1'h0;
    else if (lk) locked = 1'h1;
    if (le) check(lock_n, 1'h1);
  endtask : run_xact

  task automatic hold_try;
    @(posedge clk_i);
    bus_hold <= 1'h1;
    repeat (3) @(posedge clk_i);
    check(hold_ack, !locked);
    check({strobe_oe, def_oe, lock_oe, pseudo_lock_oe}, locked ? 4'hf : 4'h0);
    bus_hold <= 1'h0;
    repeat (3) @(posedge clk_i);
    check({hold_ack, strobe_oe, def_oe, lock_oe, pseudo_lock_oe}, 5'h0f);
  endtask : hold_try

  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [1:0]  xv;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'h1;
    for (int k = 0; k < 7; k++) run_xact(3'(k), 2'h0, 0, 0, 1, 1, 1, 0);
    run_xact(3'h4, 2'h0, 0, 0, 1, 1, 0, 0);
    run_xact(3'h5, 2'h0, 0, 0, 1, 0, 0, 1);
    run_xact(3'h6, 2'h1, 0, 0, 1, 1, 1, 0);
    run_xact(3'h6, 2'h1, 0, 0, 1, 0, 1, 0);
    run_xact(3'h5, 2'h2, 0, 0, 0, 1, 1, 0);
    hold_try();
    run_xact(3'h5, 2'h0, 1, 0, 1, 1, 0, 0);
    hold_try();
    run_xact(3'h6, 2'h0, 1, 1, 1, 1, 1, 1);
    hold_try();
    for (int i = 0; i < 40; i++) begin
      r  = lfsr;
      xv = (r[2:0] % 3'h7 >= 3'h5) ? r[4:3] % 2'h3 : 2'h0;
      if (xv == 2'h2 && r[2:0] % 3'h7 == 3'h6) xv = 2'h1;
      run_xact(r[2:0] % 3'h7, xv, r[5] & r[6] & (r[2:0] % 3'h7 >= 3'h5), r[7], r[8], r[9], r[10],
               r[11] & r[12]);
    end
    close_out();
  end

  initial begin
    #500000;
    err_total++;
    close_out();
  end
endmodule : tb_cpu_bus_cycle_definition
`default_nettype wire
